//--- verilog/pps_pkg.sv
// Purpose: Shared constants, types and decoders of the paging scheduler.
// Assumes: A 10 MHz mclk; every duration is counted in 5 us ticks.
// Notes:   Durations are held as 32-bit tick counts; the longest extended
//          cycle needs 31 bits.
package pps_pkg;

  // Clock and common time base.
  localparam int unsigned CLK_NS   = 100;
  localparam int unsigned TICK_NS  = 5000;
  localparam int unsigned TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

  // GSM paging interval: frame time times frames per multiframe times DRX.
  localparam int unsigned GSM_FRAME_US = 4615;
  localparam logic [31:0] GSM_FRAME_TICKS =
    32'(GSM_FRAME_US * 1000 / TICK_NS);
  localparam logic [31:0] GSM_FRAMES  = 32'h0000_0033;
  localparam logic [3:0]  GSM_DRX_MIN = 4'h2;
  localparam logic [3:0]  GSM_DRX_MAX = 4'h9;

  // LTE paging interval unit and the length of one paging occasion.
  localparam int unsigned LTE_UNIT_MS    = 10;
  localparam logic [31:0] LTE_UNIT_TICKS =
    32'(LTE_UNIT_MS * 1000000 / TICK_NS);
  localparam int unsigned PAGE_OCC_MS    = 10;
  localparam logic [31:0] PAGE_OCC_TICKS =
    32'(PAGE_OCC_MS * 1000000 / TICK_NS);

  // Allowed LTE DRX cycle values per category.
  localparam logic [10:0] M1_DRX [4] = '{11'h080, 11'h100, 11'h200, 11'h400};
  localparam logic [10:0] NB_DRX [4] = '{11'h020, 11'h040, 11'h080, 11'h100};

  // Extended cycle: 5.12 s shifted left by (code - offset), at most 11.
  localparam int unsigned PCL_BASE_MS    = 5120;
  localparam logic [31:0] PCL_BASE_TICKS =
    32'(PCL_BASE_MS * 1000 / TICK_NS * 1000);
  localparam logic [3:0]  PCL_CODE_OFS   = 4'h4;
  localparam logic [3:0]  PCL_MAX_EXP    = 4'hb;
  localparam int unsigned PTW_UNIT_MS    = 2560;
  localparam logic [31:0] PTW_UNIT_TICKS =
    32'(PTW_UNIT_MS * 1000 / TICK_NS * 1000);
  localparam logic [3:0]  PCL_DEF        = 4'hd;
  localparam logic [3:0]  PTW_DEF        = 4'h4;

  // Radio access the device is camped on.
  typedef enum logic [1:0] {
    NET_NONE = 2'b00,
    NET_GSM  = 2'b01,
    NET_M1   = 2'b10,
    NET_NB   = 2'b11
  } pps_net_t;

  // Scheduler power states.
  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_LISTEN = 3'b001,
    ST_SLEEP  = 3'b010,
    ST_PSM    = 3'b011,
    ST_ESUSP  = 3'b100
  } pps_state_t;

  // Whole state of the scheduler.
  typedef struct packed {
    pps_state_t  fsm;
    pps_net_t    net;
    logic        edrx;
    logic        psm;
    logic        cfgErr;
    logic        ctxHeld;
    logic [31:0] periodLen;
    logic [31:0] edrxLen;
    logic [31:0] ptwLen;
    logic [31:0] cycCnt;
    logic [31:0] winCnt;
  } pps_sched_st_t;

  // Whole state of the time base.
  typedef struct packed {
    logic [15:0] div;
    logic [31:0] atCnt;
  } pps_tick_st_t;

  // True when an LTE DRX value belongs to the category's set of four.
  function automatic logic pps_lte_drx_ok(input pps_net_t net,
                                          input logic [10:0] v);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (net == NET_M1 && v == M1_DRX[i]) ok = 1'b1;
      if (net == NET_NB && v == NB_DRX[i]) ok = 1'b1;
    end
    return ok;
  endfunction : pps_lte_drx_ok

  // Extended paging cycle length in ticks for a cycle-length code.
  function automatic logic [31:0] pps_pcl_ticks(input logic [3:0] code);
    logic [3:0] e;
    e = (code < PCL_CODE_OFS) ? 4'h0 : 4'(code - PCL_CODE_OFS);
    if (e > PCL_MAX_EXP) e = PCL_MAX_EXP;
    return PCL_BASE_TICKS << e;
  endfunction : pps_pcl_ticks

  // Paging window length in ticks: (code + 1) window units.
  function automatic logic [31:0] pps_ptw_ticks(input logic [3:0] code);
    return 32'(({28'h0, code} + 32'h1) * PTW_UNIT_TICKS);
  endfunction : pps_ptw_ticks

endpackage : pps_pkg

//--- verilog/pps_time_if.sv
// Purpose: Carries the common tick and the active timer between modules.
// Assumes: One clock; all signals are synchronous to mclk.
// Notes:   atRunning is a decode of the timer register, valid the cycle
//          after atLoad.
`timescale 1ns/10ps
interface pps_time_if;
  logic        tick;
  logic        atLoad;
  logic [31:0] atValue;
  logic        atRunning;

  // Time base side and scheduler side.
  modport gen   (output tick, atRunning, input atLoad, atValue);
  modport sched (input tick, atRunning, output atLoad, atValue);
endinterface : pps_time_if

//--- verilog/pps_tick_gen.sv
// Purpose: Free-running tick divider and the active-timer countdown.
// Assumes: Synchronous active-low reset.
// Notes:   A load of zero leaves the timer stopped at once.
`timescale 1ns/10ps
module pps_tick_gen #(
  parameter int unsigned TICK_CYC = pps_pkg::TICK_CYC
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Time base towards the scheduler.
  pps_time_if.gen  tm
);
  import pps_pkg::*;

  pps_tick_st_t st_r;
  pps_tick_st_t st_nxt;
  logic         tickNow;

  // One tick every TICK_CYC cycles; the timer counts ticks.
  always_comb begin
    st_nxt  = st_r;
    tickNow = (st_r.div == 16'(TICK_CYC - 1));
    st_nxt.div = tickNow ? 16'h0000 : 16'(st_r.div + 16'h0001);
    if (tm.atLoad) begin
      st_nxt.atCnt = tm.atValue;
    end else if (tickNow && st_r.atCnt != 32'h0) begin
      st_nxt.atCnt = 32'(st_r.atCnt - 32'h1);
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tm.tick      = tickNow;
  assign tm.atRunning = |st_r.atCnt;

  // The timer steps down by exactly one per tick while running.
  AST_AT_STEP: assert property (@(posedge mclk) disable iff (!rst_b)
    (tm.tick && tm.atRunning && !tm.atLoad)
      |=> st_r.atCnt == 32'($past(st_r.atCnt) - 32'h1))
    else $error("Active timer did not step by one tick.");

endmodule : pps_tick_gen

//--- verilog/pps_scheduler.sv
// Purpose: Paging-monitor and sleep interval scheduler for a cellular
//          module under GSM DRX, LTE DRX and LTE extended DRX, with
//          power-save entry after the active timer.
// Assumes: Config inputs are stable while cfgLoad is high; durations run
//          from a common 5 us tick.
// Notes:   TICK_CYC may be lowered in simulation to shrink every interval.
`timescale 1ns/10ps
module pps_scheduler #(
  parameter int unsigned TICK_CYC = pps_pkg::TICK_CYC
) (
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // Network-assigned configuration, taken on cfgLoad; activeTimer is read when the timer is armed.
  input  wire logic              cfgLoad,
  input  wire pps_pkg::pps_net_t netMode,
  input  wire logic [3:0]        gsmDrx,
  input  wire logic [10:0]       lteDrx,
  input  wire logic              edrxGrant,
  input  wire logic              psmGrant,
  input  wire logic              codesNegotiated,
  input  wire logic [3:0]        pclCode,
  input  wire logic [3:0]        ptwCode,
  input  wire logic [31:0]       activeTimer,
  // Power-state control.
  input  wire logic              idleStart,
  input  wire logic              uplinkPending,
  input  wire logic              edrxSuspendEn,
  input  wire logic              psmWake,
  input  wire logic              detach,
  // Status.
  output logic                   pagingListen,
  output logic                   sleepOn,
  output logic                   psmSuspend,
  output logic                   edrxSuspend,
  output logic                   edrxActive,
  output logic                   activeRunning,
  output logic                   contextHeld,
  output logic                   cfgError
);
  import pps_pkg::*;

  pps_sched_st_t st_r;
  pps_sched_st_t st_nxt;
  pps_time_if    tm ();

  logic [31:0] cycleLen;
  logic [31:0] winLen;
  logic        atExpired;
  logic        esuspBlock;
  logic        psmGo;
  logic        cfgOk;
  logic        cycleEnd;
  logic        winEnd;
  logic        awake;

  // Common time base and active timer.
  pps_tick_gen #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .mclk  (mclk),
    .rst_b (rst_b),
    .tm    (tm)
  );

  // Lengths of the current cycle and listening window.
  always_comb begin
    cycleLen = st_r.edrx ? st_r.edrxLen : st_r.periodLen;
    winLen   = st_r.edrx ? st_r.ptwLen : PAGE_OCC_TICKS;
  end

  // Validity of the offered configuration, per radio access.
  always_comb begin
    case (netMode)
      NET_GSM: cfgOk = (gsmDrx >= GSM_DRX_MIN)
                    && (gsmDrx <= GSM_DRX_MAX);
      NET_M1:  cfgOk = pps_lte_drx_ok(netMode, lteDrx);
      NET_NB:  cfgOk = pps_lte_drx_ok(netMode, lteDrx);
      default: cfgOk = 1'b0;
    endcase
  end

  // Power-save entry conditions. The active timer only gates this when
  // power save was granted; with extended DRX alone there is no timer.
  always_comb begin
    atExpired  = st_r.psm && !tm.atRunning;
    esuspBlock = edrxSuspendEn && st_r.edrx;
    awake      = (st_r.fsm == ST_LISTEN) || (st_r.fsm == ST_SLEEP);
    psmGo      = atExpired && !uplinkPending
              && !esuspBlock && awake;
    cycleEnd   = tm.tick && (st_r.cycCnt <= 32'h1);
    winEnd     = tm.tick && (st_r.winCnt <= 32'h1);
  end

  // When power save was granted, the active timer is armed whenever
  // scheduling (re)starts from idle or from a power-save wake.
  always_comb begin
    tm.atValue = activeTimer;
    tm.atLoad  = st_r.psm && ((st_r.fsm == ST_OFF && idleStart)
              || (st_r.fsm == ST_PSM && psmWake));
  end

  // Next-state logic: configuration capture and the power-state machine.
  always_comb begin
    st_nxt = st_r;

    // Configuration capture; a refused set keeps the previous one.
    if (cfgLoad) begin
      st_nxt.cfgErr = !cfgOk;
      if (cfgOk) begin
        st_nxt.net  = netMode;
        st_nxt.psm  = psmGrant;
        st_nxt.edrx = edrxGrant && (netMode != NET_GSM);
        if (netMode == NET_GSM) begin
          st_nxt.periodLen = 32'(GSM_FRAME_TICKS * GSM_FRAMES
                           * {28'h0, gsmDrx});
        end else begin
          st_nxt.periodLen = 32'({21'h0, lteDrx}
                           * LTE_UNIT_TICKS);
        end
        if (codesNegotiated) begin
          st_nxt.edrxLen = pps_pcl_ticks(pclCode);
          st_nxt.ptwLen  = pps_ptw_ticks(ptwCode);
        end else begin
          st_nxt.edrxLen = pps_pcl_ticks(PCL_DEF);
          st_nxt.ptwLen  = pps_ptw_ticks(PTW_DEF);
        end
      end
    end

    // Power-state machine. A cycle end always restarts the window, so a
    // window longer than its cycle simply listens without a break.
    case (st_r.fsm)
      ST_OFF: begin
        if (idleStart && st_r.net != NET_NONE) begin
          st_nxt.fsm     = ST_LISTEN;
          st_nxt.cycCnt  = cycleLen;
          st_nxt.winCnt  = winLen;
          st_nxt.ctxHeld = 1'b1;
        end
      end
      ST_LISTEN, ST_SLEEP, ST_ESUSP: begin
        if (tm.tick) begin
          st_nxt.cycCnt = 32'(st_r.cycCnt - 32'h1);
          st_nxt.winCnt = (st_r.winCnt == 32'h0) ? 32'h0
                        : 32'(st_r.winCnt - 32'h1);
        end
        if (cycleEnd) begin
          st_nxt.fsm    = ST_LISTEN;
          st_nxt.cycCnt = cycleLen;
          st_nxt.winCnt = winLen;
        end else if (st_r.fsm == ST_LISTEN && winEnd) begin
          st_nxt.fsm = (st_r.edrx && edrxSuspendEn)
                     ? ST_ESUSP : ST_SLEEP;
        end
        // A cycle end still wins, so a dropped suspend never skips a window.
        if (st_r.fsm == ST_ESUSP && !cycleEnd
            && !(edrxSuspendEn && st_r.edrx)) begin
          st_nxt.fsm = ST_SLEEP;
        end
        if (psmGo) begin
          st_nxt.fsm = ST_PSM;
        end
      end
      ST_PSM: begin
        // Context stays held: a wake resumes paging without idleStart.
        if (psmWake) begin
          st_nxt.fsm    = ST_LISTEN;
          st_nxt.cycCnt = cycleLen;
          st_nxt.winCnt = winLen;
        end
      end
      default: begin
        st_nxt.fsm = ST_OFF;
      end
    endcase

    // Detach drops the context and stops all scheduling.
    if (detach) begin
      st_nxt.fsm     = ST_OFF;
      st_nxt.ctxHeld = 1'b0;
      st_nxt.cycCnt  = 32'h0;
      st_nxt.winCnt  = 32'h0;
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Status outputs are decodes of the state register. Listening stops the
  // moment a granted active timer has run out, even if power save is
  // still held off by pending uplink traffic.
  always_comb begin
    pagingListen  = (st_r.fsm == ST_LISTEN) && !atExpired;
    sleepOn       = (st_r.fsm == ST_SLEEP)
                 || ((st_r.fsm == ST_LISTEN) && atExpired);
    psmSuspend    = (st_r.fsm == ST_PSM);
    edrxSuspend   = (st_r.fsm == ST_ESUSP);
    edrxActive    = st_r.edrx;
    activeRunning = tm.atRunning;
    contextHeld   = st_r.ctxHeld;
    cfgError      = st_r.cfgErr;
  end

  // Checks.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence sWinClose;
    (st_r.fsm == ST_LISTEN) && winEnd && !cycleEnd && !psmGo && !detach;
  endsequence

  sequence sCycleClose;
    ((st_r.fsm == ST_SLEEP) || (st_r.fsm == ST_ESUSP)) && cycleEnd
      && !psmGo && !detach;
  endsequence

  sequence sGsmLoad;
    cfgLoad && netMode == NET_GSM && cfgOk;
  endsequence

  sequence sCodeLoad;
    cfgLoad && cfgOk && codesNegotiated;
  endsequence

  AST_GSM_PERIOD: assert property (
    sGsmLoad |=> st_r.periodLen == 32'(GSM_FRAME_TICKS * GSM_FRAMES
      * {28'h0, $past(gsmDrx)}))
    else $error("GSM interval length is wrong.");

  AST_GSM_REFUSE: assert property (
    (cfgLoad && netMode == NET_GSM
      && (gsmDrx < GSM_DRX_MIN || gsmDrx > GSM_DRX_MAX))
      |=> cfgError && $stable(st_r.periodLen))
    else $error("Out-of-range GSM DRX was not refused.");

  AST_LTE_PERIOD: assert property (
    (cfgLoad && netMode != NET_GSM && cfgOk)
      |=> st_r.periodLen == 32'({21'h0, $past(lteDrx)} * LTE_UNIT_TICKS))
    else $error("LTE interval length is wrong.");

  AST_LTE_SET: assert property (
    (cfgLoad && (netMode == NET_M1 || netMode == NET_NB)
      && !pps_lte_drx_ok(netMode, lteDrx)) |=> cfgError)
    else $error("Unsupported LTE DRX value was accepted.");

  AST_GSM_NO_EDRX: assert property (
    (st_r.net == NET_GSM) |-> !edrxActive)
    else $error("Extended DRX active on GSM.");

  AST_PTW_LEN: assert property (
    (cfgLoad && cfgOk && !codesNegotiated)
      |=> st_r.ptwLen == 32'h0027_1000 && st_r.edrxLen == 32'h1f40_0000)
    else $error("Default window or cycle length is wrong.");

  AST_WIN_SLEEP: assert property (
    sWinClose |=> (sleepOn || edrxSuspend) && !pagingListen)
    else $error("No return to sleep after the paging window.");

  AST_RELOAD: assert property (
    sCycleClose |=> pagingListen || (st_r.fsm == ST_LISTEN)
      ##0 st_r.cycCnt == $past(cycleLen))
    else $error("Cycle did not reload and reopen the window.");

  AST_PSM_ENTRY: assert property (
    $rose(psmSuspend) |-> $past(st_r.psm) && !$past(tm.atRunning))
    else $error("Power save entered with the active timer running.");

  AST_PSM_UPLINK: assert property (
    $rose(psmSuspend) |-> !$past(uplinkPending))
    else $error("Power save entered with uplink pending.");

  AST_LISTEN_TIMER: assert property (
    (st_r.psm && !activeRunning) |-> !pagingListen)
    else $error("Paging monitored after active timer expiry.");

  AST_ESUSP_BLOCK: assert property (
    (!psmSuspend && edrxSuspendEn && st_r.edrx) |=> !psmSuspend)
    else $error("Power save entered while extended suspend enabled.");

  AST_CONTEXT: assert property (
    (psmSuspend && psmWake && !detach) |=> contextHeld && pagingListen
      || (contextHeld && st_r.fsm == ST_LISTEN))
    else $error("Wake from power save lost the context.");

  AST_PCL_SPAN: assert property (
    sCodeLoad |=> st_r.edrxLen >= PCL_BASE_TICKS
      && st_r.edrxLen <= (PCL_BASE_TICKS << PCL_MAX_EXP))
    else $error("Extended cycle length out of span.");

  AST_PTW_CODE: assert property (
    sCodeLoad |=> st_r.ptwLen
      == 32'(({28'h0, $past(ptwCode)} + 32'h1) * PTW_UNIT_TICKS))
    else $error("Negotiated window length is wrong.");

  AST_ESUSP_EDRX: assert property (
    $rose(edrxSuspend) |-> $past(st_r.edrx))
    else $error("Extended suspend entered without extended DRX.");

  AST_PSM_ONLY: assert property (
    (cfgLoad && cfgOk && psmGrant && !edrxGrant) |=> !edrxActive)
    else $error("Extended cycles used with power save only.");

endmodule : pps_scheduler

//--- bench/pps_net_model.sv
// Purpose: Network model that assigns paging and power-save grants.
// Assumes: Fields change by non-blocking assignment at a rising edge.
// Notes:   Illegal values are sent only when a test expects a refusal.
`timescale 1ns/10ps
module pps_net_model (
  // Clock.
  input  wire logic         mclk,
  // Assigned configuration.
  output logic              cfgLoad,
  output pps_pkg::pps_net_t netMode,
  output logic [3:0]        gsmDrx,
  output logic [10:0]       lteDrx,
  output logic              edrxGrant,
  output logic              psmGrant,
  output logic              codesNegotiated,
  output logic [3:0]        pclCode,
  output logic [3:0]        ptwCode,
  output logic [31:0]       activeTimer
);
  import pps_pkg::*;

  // Quiet cell at start: nothing assigned yet.
  initial begin
    cfgLoad         = 1'b0;
    netMode         = NET_NONE;
    gsmDrx          = 4'h0;
    lteDrx          = 11'h000;
    edrxGrant       = 1'b0;
    psmGrant        = 1'b0;
    codesNegotiated = 1'b0;
    pclCode         = 4'h5;
    ptwCode         = 4'h1;
    activeTimer     = 32'h0;
  end

  // One assignment; a busy cell idles first when slow is nonzero.
  task assign_cfg(input pps_net_t n, input logic [3:0] g,
                  input logic [10:0] l, input logic e, input logic p,
                  input logic [31:0] t, input int slow);
    repeat (slow) @(posedge mclk);
    @(posedge mclk);
    netMode     <= n;
    gsmDrx      <= g;
    lteDrx      <= l;
    edrxGrant   <= e;
    psmGrant    <= p;
    activeTimer <= t;
    cfgLoad     <= 1'b1;
    @(posedge mclk);
    cfgLoad     <= 1'b0;
    // The DRX values are gone after the load, so stale reads show up.
    gsmDrx      <= ~g;
    lteDrx      <= ~l;
  endtask : assign_cfg

  // Negotiated cycle and window codes; off means the defaults apply.
  task set_codes(input logic c, input logic [3:0] pc,
                 input logic [3:0] pw);
    @(posedge mclk);
    codesNegotiated <= c;
    pclCode         <= pc;
    ptwCode         <= pw;
  endtask : set_codes
endmodule : pps_net_model

//--- bench/pps_scheduler_tb.sv
// Purpose: Self-checking bench of the paging scheduler.
// Assumes: A short tick of TC clocks keeps every window in reach.
// Notes:   Full GSM and extended cycles are too long to run here.
`timescale 1ns/10ps
module pps_scheduler_tb;
  import pps_pkg::*;
  localparam int unsigned TC = 1;

  // Bench controls, network fields and design status.
  logic mclk, rst_b, idleStart, uplinkPending, edrxSuspendEn, psmWake;
  logic detach, cfgLoad, edrxGrant, psmGrant, codesNegotiated;
  logic pagingListen, sleepOn, psmSuspend, edrxSuspend, edrxActive;
  logic activeRunning, contextHeld, cfgError;
  pps_net_t    netMode;
  logic [3:0]  gsmDrx, pclCode, ptwCode;
  logic [10:0] lteDrx;
  logic [31:0] activeTimer;
  logic [7:0]  st;
  int          fails, checks, n;
  pps_net_t    nets [3] = '{NET_GSM, NET_M1, NET_NB};
  logic [3:0]  gv [6] = '{4'h1, 4'h2, 4'h9, 4'ha, 4'h0, 4'hf};

  // Status bits in one word: 7 listen, 6 sleep, 5 power save.
  assign st = {pagingListen, sleepOn, psmSuspend, edrxSuspend,
               edrxActive, activeRunning, contextHeld, cfgError};

  pps_scheduler #(.TICK_CYC(TC)) i_pps_scheduler (
    .mclk(mclk), .rst_b(rst_b), .cfgLoad(cfgLoad), .netMode(netMode),
    .gsmDrx(gsmDrx), .lteDrx(lteDrx), .edrxGrant(edrxGrant),
    .psmGrant(psmGrant), .codesNegotiated(codesNegotiated),
    .pclCode(pclCode), .ptwCode(ptwCode), .activeTimer(activeTimer),
    .idleStart(idleStart), .uplinkPending(uplinkPending),
    .edrxSuspendEn(edrxSuspendEn), .psmWake(psmWake), .detach(detach),
    .pagingListen(pagingListen), .sleepOn(sleepOn),
    .psmSuspend(psmSuspend), .edrxSuspend(edrxSuspend),
    .edrxActive(edrxActive), .activeRunning(activeRunning),
    .contextHeld(contextHeld), .cfgError(cfgError));

  pps_net_model i_pps_net_model (
    .mclk(mclk), .cfgLoad(cfgLoad), .netMode(netMode), .gsmDrx(gsmDrx),
    .lteDrx(lteDrx), .edrxGrant(edrxGrant), .psmGrant(psmGrant),
    .codesNegotiated(codesNegotiated), .pclCode(pclCode),
    .ptwCode(ptwCode), .activeTimer(activeTimer));

  // Free-running 10 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  task check_num(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_num

  // Sampling one step after the edge keeps clear of edge races.
  task step(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : step

  // Bounded wait for a status bit; running out ends the run.
  task wait_bit(input int k, input logic v, input int lim);
    n = 0;
    // Look only once the edge that may change the bit has settled.
    #1;
    while (st[k] !== v) begin
      if (n == lim) begin
        fails++;
        $display("wrong value at %0t: got %h expected %h", $time, st[k], v);
        report_and_stop();
      end
      step(1);
      n++;
    end
  endtask : wait_bit

  // One-cycle control pulse: 0 idle start, 1 wake, 2 detach.
  task pulse(input int k);
    @(posedge mclk);
    case (k)
      0: idleStart <= 1'b1;
      1: psmWake <= 1'b1;
      default: detach <= 1'b1;
    endcase
    @(posedge mclk);
    idleStart <= 1'b0;
    psmWake   <= 1'b0;
    detach    <= 1'b0;
    #1;
  endtask : pulse

  task cfg(input pps_net_t nm, input logic [3:0] g, input logic [10:0] l,
           input logic e, input logic p, input logic [31:0] t);
    i_pps_net_model.assign_cfg(nm, g, l, e, p, t, 0);
    step(1);
  endtask : cfg

  task done(input string s);
    $display("test %s done", s);
  endtask : done

  // Main sequence.
  initial begin
    fails = 0;
    checks = 0;
    rst_b = 1'b0;
    idleStart = 1'b0;
    uplinkPending = 1'b0;
    edrxSuspendEn = 1'b0;
    psmWake = 1'b0;
    detach = 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    step(1);
    check_num({24'h0, st}, 32'h0);
    done("reset");
    // GSM values outside 2..9 are refused.
    for (int i = 0; i < 6; i++) begin
      cfg(NET_GSM, gv[i], 11'h080, 1'b0, 1'b0, 32'h0);
      check_bit(cfgError, !(gv[i] >= 4'h2 && gv[i] <= 4'h9));
    end
    done("gsm_range");
    // Each category keeps its own four cycle values.
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 6; i++) begin
        cfg(nets[c+1], 4'h2, 11'h020 << i, 1'b0, 1'b0, 32'h0);
        check_bit(cfgError, c == 0 ? i < 2 : i > 3);
      end
    end
    done("lte_sets");
    foreach (nets[i]) begin
      cfg(nets[i], 4'h2, 11'h080, 1'b1, 1'b0, 32'h0);
      check_bit(edrxActive, nets[i] != NET_GSM);
    end
    done("edrx_net");
    // Negotiated codes, then the defaults, set the extended lengths.
    i_pps_net_model.set_codes(1'b1, 4'hf, 4'h0);
    cfg(NET_M1, 4'h2, 11'h080, 1'b1, 1'b0, 32'h0);
    check_num(i_pps_scheduler.st_r.edrxLen, 32'h7d00_0000);
    check_num(i_pps_scheduler.st_r.ptwLen, 32'h0007_d000);
    i_pps_net_model.set_codes(1'b0, 4'h5, 4'h1);
    cfg(NET_M1, 4'h2, 11'h080, 1'b1, 1'b0, 32'h0);
    check_num(i_pps_scheduler.st_r.edrxLen, 32'h1f40_0000);
    check_num(i_pps_scheduler.st_r.ptwLen, 32'h0027_1000);
    done("edrx_codes");
    // Ordinary cycle: one paging occasion, then sleep.
    cfg(NET_NB, 4'h2, 11'h020, 1'b0, 1'b0, 32'h0);
    pulse(0);
    check_bit(pagingListen, 1'b1);
    wait_bit(6, 1'b1, 2001 * TC + 4);
    check_bit(n >= 2000 * TC - 1 && n <= 2001 * TC + 2, 1'b1);
    check_bit(pagingListen, 1'b0);
    check_bit(activeRunning, 1'b0);
    // The 320 ms cycle reopens the window after the sleep.
    wait_bit(7, 1'b1, 62000 * TC + 4);
    check_bit(n >= 62000 * TC - 1 && n <= 62000 * TC + 2, 1'b1);
    pulse(2);
    check_num({30'h0, st[7:6]}, 32'h0);
    done("drx_window");
    // Zero active timer: straight into power save, context kept.
    cfg(NET_M1, 4'h2, 11'h080, 1'b0, 1'b1, 32'h0);
    pulse(0);
    step(1);
    check_bit(psmSuspend, 1'b1);
    check_bit(contextHeld, 1'b1);
    check_bit(pagingListen, 1'b0);
    // A zero timer re-armed on wake has already run out.
    pulse(1);
    check_bit(psmSuspend, 1'b0);
    check_bit(pagingListen, 1'b0);
    check_bit(sleepOn, 1'b1);
    check_bit(contextHeld, 1'b1);
    step(1);
    check_bit(psmSuspend, 1'b1);
    pulse(2);
    check_bit(contextHeld, 1'b0);
    done("psm_zero");
    // Pending uplink holds power save off until it clears.
    @(posedge mclk);
    uplinkPending <= 1'b1;
    pulse(0);
    step(4);
    check_bit(psmSuspend, 1'b0);
    check_bit(sleepOn, 1'b1);
    @(posedge mclk);
    uplinkPending <= 1'b0;
    wait_bit(5, 1'b1, 4);
    pulse(2);
    done("uplink");
    // Extended suspend enabled: regular power save is barred.
    @(posedge mclk);
    edrxSuspendEn <= 1'b1;
    cfg(NET_M1, 4'h2, 11'h080, 1'b1, 1'b1, 32'h0);
    pulse(0);
    step(8);
    check_bit(psmSuspend, 1'b0);
    check_bit(edrxActive, 1'b1);
    pulse(2);
    @(posedge mclk);
    edrxSuspendEn <= 1'b0;
    done("edrx_susp");
    // Power save only: ordinary paging until the timer runs out.
    i_pps_net_model.assign_cfg(NET_NB, 4'h2, 11'h040, 1'b0, 1'b1,
                               32'h0000_000a, 3);
    step(1);
    pulse(0);
    check_bit(activeRunning, 1'b1);
    check_bit(pagingListen, 1'b1);
    check_bit(edrxActive, 1'b0);
    wait_bit(5, 1'b1, 10 * TC + 8);
    check_bit(n >= 10 * TC - 4, 1'b1);
    check_bit(activeRunning, 1'b0);
    check_bit(pagingListen, 1'b0);
    // A wake re-arms the timer and paging resumes at once.
    pulse(1);
    check_bit(pagingListen, 1'b1);
    check_bit(activeRunning, 1'b1);
    pulse(2);
    done("active_timer");
    report_and_stop();
  end
endmodule : pps_scheduler_tb
